// ===== hw/spi_cfg_defines.svh
/*
  Constants of the serial configuration port: frame layout, bit
  positions and timing counts shared by both ends.
  Assumes a 100 MHz system clock and a serial clock of 2 MHz at most.
*/
// ==========================================================================
// Overview of operation
// [R1] host sends zero flag for writes
// [R2] device shifts data in on rising clock
// [R3] clock counts only while select is low
// [R4] host idles clock low, samples rising edge
// [R5] host holds select high when idle
// [R6] host sends one flag for reads
// [R7] readback pin low during address bits
// [R8] read data leaves on falling clock edge
// [R9] device ignores data input during reads
// [R10] readback keeps driving until enable cleared
// [R11] readback shows effective state, not writes
// [R12] flag, 7-bit address, 16-bit data, MSB first
`ifndef SPI_CFG_DEFINES_SVH
`define SPI_CFG_DEFINES_SVH

// ==========================================================================
// frame layout
`define SPI_FRAME_BITS   24
`define SPI_HDR_BITS     8
`define SPI_ADDR_BITS    7
`define SPI_DATA_BITS    16
`define SPI_CNT_W        5
`define SPI_RW_POS       23
`define SPI_ADDR_MSB     22
`define SPI_ADDR_LSB     16
`define SPI_DATA_MSB     15
`define SPI_RW_WRITE     1'b0
`define SPI_RW_READ      1'b1

// ==========================================================================
// timing
`define SPI_MCLK_NS      10
`define SPI_HALF_NS      250
`define SPI_EWH_NS       50
`define SPI_HALF_CYC     ((`SPI_HALF_NS + `SPI_MCLK_NS - 1) / `SPI_MCLK_NS)
`define SPI_EWH_CYC      ((`SPI_EWH_NS + `SPI_MCLK_NS - 1) / `SPI_MCLK_NS)
`define SPI_DIV_W        8

// ==========================================================================
// readback release word
`define SPI_RB_CTRL_ADDR 7'h00
`define SPI_RB_RELEASE   16'h0000

`endif

// ===== hw/spi_cfg_device.sv
/*
  Device end of the serial configuration port: frame receiver on the
  serial clock, readback shifter on its falling edge, and the write
  hand-off into the system clock domain.
  Assumes the user presents, on rd_data, the effective state for rd_addr
  and holds it steady through a read frame; the host drives the link.
*/
`timescale 1ns/100ps
`include "spi_cfg_defines.svh"

module spi_cfg_device
  import spi_cfg_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  spi_cfg_if.device                      link,
  output logic [`SPI_ADDR_BITS-1:0]      rd_addr,
  input  wire logic [`SPI_DATA_BITS-1:0] rd_data,
  input  wire logic                      readback_drive_enable,
  output logic                           wr_valid,
  output logic [`SPI_ADDR_BITS-1:0]      wr_addr,
  output logic [`SPI_DATA_BITS-1:0]      wr_data
);

  // ========================================================================
  // declarations
  link_st_t                  lnk;
  link_st_t                  next_lnk;
  hold_st_t                  hold;
  hold_st_t                  next_hold;
  rb_st_t                    rb;
  rb_st_t                    next_rb;
  dev_st_t                   dev;
  dev_st_t                   next_dev;
  logic [`SPI_FRAME_BITS-1:0] frame;
  logic [`SPI_FRAME_BITS-1:0] full;
  logic                      frame_shift;
  logic                      in_data;

  localparam dev_st_t DEV_RESET = '{
    cs_sync:  2'h3,
    ok_sync:  2'h0,
    cs_prev:  1'b1,
    wr_valid: 1'b0,
    wr_addr:  '0,
    wr_data:  '0,
    oe_n:     1'b1
  };

  // ========================================================================
  // frame receiver, serial clock domain
  assign in_data = (lnk.cnt >= `SPI_CNT_W'(`SPI_HDR_BITS));

  // stop shifting once the frame is full or a read reaches its data part
  assign frame_shift = !link.cs_n                                    // R3
                     && (lnk.cnt != `SPI_CNT_W'(`SPI_FRAME_BITS))
                     && !(in_data && lnk.rw == `SPI_RW_READ);         // R9

  spi_shift #(
    .W (`SPI_FRAME_BITS)
  ) u_frame (
    .clk      (link.sck),
    .load     (1'b0),
    .load_val ('0),
    .shift    (frame_shift),                                         // R2
    .din      (link.sdi),
    .q        (frame)
  );

  // the word as it stands once the current bit is in
  assign full = {frame[`SPI_FRAME_BITS-2:0], link.sdi};

  always_comb
  begin
    next_lnk = lnk;
    if (lnk.cnt != `SPI_CNT_W'(`SPI_FRAME_BITS))
    begin
      next_lnk.cnt = lnk.cnt + `SPI_CNT_W'(1);
    end
    // flag is the first bit, fixed after the eighth edge
    if (lnk.cnt == `SPI_CNT_W'(`SPI_HDR_BITS - 1))
    begin
      next_lnk.rw = frame[`SPI_HDR_BITS-2];                          // R12
    end
  end

  // select high clears the count, so stray pulses never count
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      lnk <= '0;                                                     // R3
    end
    else
    begin
      lnk <= next_lnk;
    end
  end

  // ========================================================================
  // write holding word, serial clock domain
  always_comb
  begin
    next_hold = hold;
    // any new frame withdraws the previous complete write
    if (lnk.cnt == '0)
    begin
      next_hold.wr_ok = 1'b0;
    end
    // flag from the counted header: a read freezes the frame, so its
    // top bits are stale from an earlier frame and would fake a write
    if (lnk.cnt == `SPI_CNT_W'(`SPI_FRAME_BITS - 1)
        && lnk.rw == `SPI_RW_WRITE)                                  // R12
    begin
      next_hold.wr_ok = 1'b1;
      next_hold.addr  = full[`SPI_ADDR_MSB:`SPI_ADDR_LSB];
      next_hold.data  = full[`SPI_DATA_MSB:0];
    end
  end

  // system reset used asynchronously: this clock may be stopped
  always_ff @(posedge link.sck or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hold <= '0;
    end
    else
    begin
      hold <= next_hold;
    end
  end

  // ========================================================================
  // readback shifter, falling serial clock edge
  // the frame freezes in a read, so the address stays put for the user
  assign rd_addr = frame[`SPI_ADDR_BITS-1:0];

  always_comb
  begin
    next_rb = rb;
    if (!in_data)
    begin
      next_rb.bit_out = 1'b0;                                        // R7
    end
    else if (lnk.rw == `SPI_RW_READ)
    begin
      if (lnk.cnt == `SPI_CNT_W'(`SPI_HDR_BITS))
      begin
        // effective state as the user reports it, not a stored write
        next_rb.bit_out = rd_data[`SPI_DATA_BITS-1];                 // R11
        next_rb.sh      = {rd_data[`SPI_DATA_BITS-2:0], 1'b0};
      end
      else if (lnk.cnt != `SPI_CNT_W'(`SPI_FRAME_BITS))
      begin
        next_rb.bit_out = rb.sh[`SPI_DATA_BITS-1];                   // R8
        next_rb.sh      = {rb.sh[`SPI_DATA_BITS-2:0], 1'b0};
      end
    end
  end

  always_ff @(negedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      rb <= '0;
    end
    else
    begin
      rb <= next_rb;                                                 // R8
    end
  end

  assign link.readback_out = rb.bit_out;

  // ========================================================================
  // system clock domain: write commit and drive enable
  always_comb
  begin
    next_dev          = dev;
    next_dev.cs_sync  = {dev.cs_sync[0], link.cs_n};
    next_dev.ok_sync  = {dev.ok_sync[0], hold.wr_ok};
    next_dev.cs_prev  = dev.cs_sync[1];
    next_dev.wr_valid = 1'b0;
    // write lands when select returns high after a complete frame
    if (dev.cs_sync[1] && !dev.cs_prev && dev.ok_sync[1])           // R12
    begin
      // holding word is static since the last edge of the frame
      next_dev.wr_valid = 1'b1;
      next_dev.wr_addr  = hold.addr;
      next_dev.wr_data  = hold.data;
    end
    // pin stays driven after a read until software clears the enable
    next_dev.oe_n = !readback_drive_enable;                          // R10
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      dev <= DEV_RESET;
    end
    else
    begin
      dev <= next_dev;
    end
  end

  // ========================================================================
  // outputs
  assign link.readback_oe_n = dev.oe_n;                              // R10
  assign wr_valid           = dev.wr_valid;
  assign wr_addr            = dev.wr_addr;
  assign wr_data            = dev.wr_data;

endmodule

// ===== hw/spi_cfg_host.sv
/*
  Host end of the serial configuration port: runs one frame per command,
  makes the serial clock by dividing the system clock, and releases the
  readback line after reads.
  Assumes the device keeps the readback drive enable at RB_CTRL_ADDR.
*/
`timescale 1ns/100ps
`include "spi_cfg_defines.svh"

module spi_cfg_host
  import spi_cfg_pkg::*;
#(
  parameter int                        HALF_CYC    = `SPI_HALF_CYC,
  parameter int                        GAP_CYC     = `SPI_EWH_CYC,
  parameter logic [`SPI_ADDR_BITS-1:0] RB_CTRL_ADDR = `SPI_RB_CTRL_ADDR
) (
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  spi_cfg_if.host                        link,
  input  wire logic                      cmd_valid,
  output logic                           cmd_ready,
  input  wire logic                      cmd_rw,
  input  wire logic [`SPI_ADDR_BITS-1:0] cmd_addr,
  input  wire logic [`SPI_DATA_BITS-1:0] cmd_data,
  output logic                           rsp_valid,
  output logic [`SPI_DATA_BITS-1:0]      rsp_data
);

  // ========================================================================
  // declarations
  host_st_t                   st;
  host_st_t                   next_st;
  logic                       tx_load;
  logic                       tx_shift;
  logic [`SPI_FRAME_BITS-1:0] tx_val;
  logic [`SPI_FRAME_BITS-1:0] tx_q;
  logic                       half_done;

  localparam logic [`SPI_DIV_W-1:0] HALF_LAST = `SPI_DIV_W'(HALF_CYC - 1);
  localparam logic [`SPI_DIV_W-1:0] GAP_LAST  = `SPI_DIV_W'(GAP_CYC - 1);

  spi_shift #(
    .W (`SPI_FRAME_BITS)
  ) u_tx (
    .clk      (mclk),
    .load     (tx_load),
    .load_val (tx_val),
    .shift    (tx_shift),
    .din      (1'b0),
    .q        (tx_q)
  );

  assign half_done = (st.div == HALF_LAST);
  assign cmd_ready = (st.state == H_IDLE);

  // ========================================================================
  // frame sequencer
  always_comb
  begin
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    next_st.rb_sync   = {st.rb_sync[0], link.readback_line};
    next_st.div       = st.div + `SPI_DIV_W'(1);
    tx_load           = 1'b0;
    tx_shift          = 1'b0;
    tx_val            = {cmd_rw, cmd_addr, cmd_data};                // R12
    case (st.state)
      H_IDLE:
      begin
        next_st.cs_n = 1'b1;                                         // R5
        next_st.sck  = 1'b0;                                         // R4
        next_st.div  = '0;
        if (cmd_valid || st.need_release)
        begin
          // user commands first; release waits for a quiet moment
          if (!cmd_valid)
          begin
            tx_val = {`SPI_RW_WRITE, RB_CTRL_ADDR, `SPI_RB_RELEASE}; // R10
          end
          tx_load      = 1'b1;
          next_st.rw   = tx_val[`SPI_RW_POS];                        // R1 R6
          next_st.bits = '0;
          next_st.cs_n = 1'b0;                                       // R3
          next_st.state = H_SETUP;
          if (tx_val[`SPI_RW_POS] == `SPI_RW_WRITE
              && tx_val[`SPI_ADDR_MSB:`SPI_ADDR_LSB] == RB_CTRL_ADDR)
          begin
            next_st.need_release = 1'b0;
          end
        end
      end
      H_SETUP:
      begin
        if (half_done)
        begin
          next_st.div   = '0;
          next_st.state = H_SHIFT;
        end
      end
      H_SHIFT:
      begin
        if (half_done)
        begin
          next_st.div = '0;
          next_st.sck = !st.sck;
          if (!st.sck)
          begin
            // rising edge: readback sampled, bit counted
            next_st.rx   = {st.rx[`SPI_DATA_BITS-2:0], st.rb_sync[1]}; // R4
            next_st.bits = st.bits + `SPI_CNT_W'(1);
          end
          else if (st.bits == `SPI_CNT_W'(`SPI_FRAME_BITS))
          begin
            next_st.state = H_GAP;
          end
          else
          begin
            tx_shift = 1'b1;
          end
        end
      end
      H_GAP:
      begin
        next_st.cs_n = 1'b1;
        if (st.div == GAP_LAST)
        begin
          next_st.state     = H_IDLE;
          next_st.rsp_valid = st.rw;
          if (st.rw == `SPI_RW_READ)
          begin
            next_st.rsp_data     = st.rx;
            next_st.need_release = 1'b1;                             // R10
          end
        end
      end
      default:
      begin
        next_st.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st       <= '0;
      st.cs_n  <= 1'b1;
      st.state <= H_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ========================================================================
  // outputs
  assign link.sck  = st.sck;
  assign link.cs_n = st.cs_n;
  assign link.sdi  = tx_q[`SPI_FRAME_BITS-1];
  assign rsp_valid = st.rsp_valid;
  assign rsp_data  = st.rsp_data;

endmodule

// ===== hw/spi_cfg_if.sv
/*
  Serial configuration link between host and device.
  Assumes the shared readback line has a pull-up when nobody drives it.
*/
`timescale 1ns/100ps

interface spi_cfg_if;
  logic sck;
  logic cs_n;
  logic sdi;
  logic readback_out;
  logic readback_oe_n;
  logic readback_line;

  // released line floats high through the pull-up
  assign readback_line = readback_oe_n ? 1'b1 : readback_out;

  modport device (
    input  sck,
    input  cs_n,
    input  sdi,
    output readback_out,
    output readback_oe_n
  );

  modport host (
    output sck,
    output cs_n,
    output sdi,
    input  readback_line
  );
endinterface

// ===== hw/spi_cfg_pkg.sv
/*
  Types of the serial configuration port: state records of both ends.
  Assumes spi_cfg_defines.svh is on the include path.
*/
`include "spi_cfg_defines.svh"

package spi_cfg_pkg;

  // ========================================================================
  // device, link side
  typedef struct packed {
    logic [`SPI_CNT_W-1:0] cnt;
    logic                  rw;
  } link_st_t;

  typedef struct packed {
    logic                      wr_ok;
    logic [`SPI_ADDR_BITS-1:0] addr;
    logic [`SPI_DATA_BITS-1:0] data;
  } hold_st_t;

  typedef struct packed {
    logic                      bit_out;
    logic [`SPI_DATA_BITS-1:0] sh;
  } rb_st_t;

  // ========================================================================
  // device, system side
  typedef struct packed {
    logic [1:0]                cs_sync;
    logic [1:0]                ok_sync;
    logic                      cs_prev;
    logic                      wr_valid;
    logic [`SPI_ADDR_BITS-1:0] wr_addr;
    logic [`SPI_DATA_BITS-1:0] wr_data;
    logic                      oe_n;
  } dev_st_t;

  // ========================================================================
  // host
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_SHIFT = 2'b11,
    H_GAP   = 2'b10
  } host_state_t;

  typedef struct packed {
    host_state_t               state;
    logic [`SPI_DIV_W-1:0]     div;
    logic [`SPI_CNT_W-1:0]     bits;
    logic                      sck;
    logic                      cs_n;
    logic                      rw;
    logic [`SPI_DATA_BITS-1:0] rx;
    logic                      rsp_valid;
    logic [`SPI_DATA_BITS-1:0] rsp_data;
    logic                      need_release;
    logic [1:0]                rb_sync;
  } host_st_t;

endpackage

// ===== hw/spi_shift.sv
/*
  Shift register, MSB first, with parallel load.
  Assumes the caller never asks for load and shift at once; load wins.
*/
`timescale 1ns/100ps

module spi_shift #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         shift,
  input  wire logic         din,
  output logic      [W-1:0] q
);
  logic [W-1:0] next_q;

  always_comb
  begin
    next_q = q;
    if (load)
    begin
      next_q = load_val;
    end
    else if (shift)
    begin
      next_q = {q[W-2:0], din};
    end
  end

  // data path only, no reset needed
  always_ff @(posedge clk)
  begin
    q <= next_q;
  end
endmodule

// ===== test/spi_cfg_link_monitor.sv
/*
  Checker on the serial link between host and device ends.
  Assumes it is instantiated beside the interface, sampled on mclk.
*/
`timescale 1ns/100ps

module spi_cfg_link_monitor #(
  parameter int GAP_CYC = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic readback_out,
  input wire logic readback_oe_n
);
  // ========================================================================
  // helper counters
  logic [5:0] rcnt;
  logic [5:0] gcnt;
  logic       sck_q;

  // sck is a host register, so mclk sampling sees every edge of it
  always_ff @(posedge mclk)
  begin
    sck_q <= sck;
    if (sys_rst || cs_n)
      rcnt <= 6'h00;
    else if (sck && !sck_q)
      rcnt <= rcnt + 6'h01;
    // out of reset the link has been idle for long enough
    if (sys_rst)
      gcnt <= 6'h3F;
    else if (!cs_n)
      gcnt <= 6'h00;
    else if (gcnt != 6'h3F)
      gcnt <= gcnt + 6'h01;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // ========================================================================
  // properties
  sequence s_oe_kept;
    !readback_oe_n [*3];
  endsequence

  AST_ADDR_LOW: assert property (!cs_n && rcnt < 6'h08 |-> !readback_out)
    else $error("readback pin not low in address bits");
  AST_RB_ON_FALL: assert property (!cs_n && $past(!cs_n) && $changed(readback_out)
    |-> $fell(sck))
    else $error("readback changed away from a falling clock");
  AST_IDLE_LOW: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  AST_SDI_ON_FALL: assert property (!cs_n && $past(!cs_n) && $changed(sdi) |-> $fell(sck))
    else $error("data moved away from a falling clock");
  AST_CS_HELD: assert property (!cs_n && rcnt > 6'h00 && rcnt < 6'h18 |=> !cs_n)
    else $error("select raised inside a frame");
  AST_FRAME_24: assert property ($rose(cs_n) |-> rcnt == 6'h18)
    else $error("frame not 24 clocks long");
  AST_SEL_GAP: assert property ($fell(cs_n) |-> gcnt >= GAP_CYC)
    else $error("select high gap too short");
  AST_OE_KEPT: assert property ($rose(cs_n) && !readback_oe_n |-> s_oe_kept)
    else $error("readback released on its own");
endmodule

// ===== test/spi_config_slave_port_tb_top.sv
/*
  Bench for host and device ends joined, plus a second device driven
  directly to break the link rules on purpose.
  Assumes the design files under hw/ and the defines on the include path.
*/
`timescale 1ns/100ps
`include "spi_cfg_defines.svh"

module spi_config_slave_port_tb_top;
  localparam int HALF = 4;
  localparam int GAP  = 2;
  logic        mclk, sys_rst, cmd_valid, cmd_rw, cmd_ready, rsp_valid, drv_en;
  logic        wr_valid, wr_valid2, last_rd;
  logic [6:0]  cmd_addr, rd_addr, wr_addr, rd_addr2, wr_addr2, a;
  logic [15:0] cmd_data, rd_data, rsp_data, wr_data, rd_data2, wr_data2, pins, rb;
  logic [15:0] mem [128];
  logic [6:0]  addrs [4];
  logic [22:0] exp_wr [$];
  logic [15:0] exp_rd [$];
  logic [31:0] seed;
  logic [23:0] w;
  int          failures, compares, cycles, wr2_cnt, i;

  spi_cfg_if u_spi_cfg_if();
  spi_cfg_if u_spi_cfg_if2();

  spi_cfg_host #(.HALF_CYC(HALF), .GAP_CYC(GAP)) u_spi_cfg_host (.mclk(mclk),
    .sys_rst(sys_rst), .link(u_spi_cfg_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_rw(cmd_rw), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  spi_cfg_device u_spi_cfg_device (.mclk(mclk), .sys_rst(sys_rst), .link(u_spi_cfg_if),
    .rd_addr(rd_addr), .rd_data(rd_data), .readback_drive_enable(drv_en),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));
  spi_cfg_device u_spi_cfg_device2 (.mclk(mclk), .sys_rst(sys_rst), .link(u_spi_cfg_if2),
    .rd_addr(rd_addr2), .rd_data(rd_data2), .readback_drive_enable(1'b1),
    .wr_valid(wr_valid2), .wr_addr(wr_addr2), .wr_data(wr_data2));
  spi_cfg_link_monitor #(.GAP_CYC(GAP)) u_spi_cfg_link_monitor (.mclk(mclk),
    .sys_rst(sys_rst), .sck(u_spi_cfg_if.sck), .cs_n(u_spi_cfg_if.cs_n),
    .sdi(u_spi_cfg_if.sdi), .readback_out(u_spi_cfg_if.readback_out),
    .readback_oe_n(u_spi_cfg_if.readback_oe_n));

  // ========================================================================
  // effective state: stored word mixed with pin levels
  assign rd_data  = mem[rd_addr] ^ pins;
  assign rd_data2 = 16'h5A00 | {9'h000, rd_addr2};

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic summarize();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [22:0] got, input logic [22:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ========================================================================
  // host command driver and model
  task automatic send(input logic rw, input logic [6:0] ad, input logic [15:0] d);
    int n;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_rw = rw;
    cmd_addr = ad;
    cmd_data = d;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 2000)
      failures = failures + 1;
    @(posedge mclk);
    last_rd = rw;
    if (rw)
      exp_rd.push_back(mem[ad] ^ pins);
    else
    begin
      exp_wr.push_back({ad, d});
      mem[ad] = d;
    end
  endtask

  // idle after a read makes the host send the release word itself
  task automatic settle();
    int n;
    @(negedge mclk);
    cmd_valid = 1'b0;
    if (last_rd)
    begin
      exp_wr.push_back(23'h000000);
      mem[0] = 16'h0000;
    end
    n = 0;
    while ((cmd_ready !== 1'b1 || exp_wr.size() != 0 || exp_rd.size() != 0) && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 3000)
      failures = failures + 1;
    repeat (4) @(negedge mclk);
    last_rd = 1'b0;
  endtask

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      summarize();
    end
    else
    begin
      if (rsp_valid === 1'b1)
      begin
        chk({7'h00, rsp_data}, {7'h00, exp_rd.pop_front()});
        chk({22'h0, u_spi_cfg_if.readback_oe_n}, 23'h0);
      end
      if (wr_valid === 1'b1)
        chk({wr_addr, wr_data}, exp_wr.pop_front());
      if (wr_valid2 === 1'b1)
        wr2_cnt <= wr2_cnt + 1;
    end
  end

  // software answer to a committed drive-enable write, off the sampling edge
  always @(negedge mclk)
  begin
    if (wr_valid === 1'b1 && wr_addr === 7'h00)
      drv_en = wr_data[0];
  end

  // ========================================================================
  // direct link driver for the second device, 6 ns serial clock
  task automatic frame2(input logic [23:0] fw, input int n);
    int k;
    logic [31:0] r;
    rb = 16'h0000;
    u_spi_cfg_if2.cs_n = 1'b0;
    #10;
    for (k = 0; k < n; k++)
    begin
      r = xs();
      u_spi_cfg_if2.sdi = (k >= 8 && fw[23]) ? r[0] : fw[23 - k];
      #3 u_spi_cfg_if2.sck = 1'b1;
      if (k >= 8)
        rb = {rb[14:0], u_spi_cfg_if2.readback_line};
      else
        chk({22'h0, u_spi_cfg_if2.readback_line}, 23'h0);
      #3 u_spi_cfg_if2.sck = 1'b0;
    end
    u_spi_cfg_if2.sdi = ~u_spi_cfg_if2.sdi;
    #30 u_spi_cfg_if2.cs_n = 1'b1;
    #100;
  endtask

  initial
  begin
    {cmd_valid, cmd_rw, cmd_addr, cmd_data, drv_en, last_rd} = '0;
    {failures, compares, cycles, wr2_cnt} = '0;
    seed = 32'h7B5F;
    pins = 16'h0000;
    u_spi_cfg_if2.sck = 1'b0;
    u_spi_cfg_if2.cs_n = 1'b1;
    u_spi_cfg_if2.sdi = 1'b0;
    for (i = 0; i < 128; i++)
      mem[i] = 16'h0000;
    sys_rst = 1'b1;
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    send(1'b0, 7'h00, 16'h0001);
    for (i = 0; i < 4; i++)
    begin
      a = 7'h01 + 7'(xs() % 126);
      addrs[i] = a;
      send(1'b0, a, 16'(xs()));
    end
    settle();
    pins = 16'h0F0F;
    for (i = 0; i < 4; i++)
      send(1'b1, addrs[i], 16'hFFFF);
    settle();
    chk({22'h0, u_spi_cfg_if.readback_oe_n}, 23'h1);
    chk({22'h0, u_spi_cfg_if.readback_line}, 23'h1);
    send(1'b0, 7'h00, 16'h0001);
    send(1'b0, 7'h7F, 16'h8001);
    send(1'b1, 7'h7F, 16'h0000);
    settle();
    // second device: stray clocks while deselected, then a whole write, a 20-clock partial write and a whole read frame
    #1.7;
    repeat (3)
    begin
      #3 u_spi_cfg_if2.sck = 1'b1;
      #3 u_spi_cfg_if2.sck = 1'b0;
    end
    w = {1'b0, 7'h2A, 16'(xs())};
    frame2(w, 24);
    chk(23'(wr2_cnt), 23'h1);
    chk({wr_addr2, wr_data2}, w[22:0]);
    frame2({1'b0, 7'h11, 16'h1234}, 20);
    chk(23'(wr2_cnt), 23'h1);
    frame2({1'b1, 7'h33, 16'h0000}, 24);
    chk({7'h00, rb}, {7'h00, 16'h5A33});
    chk(23'(wr2_cnt), 23'h1);
    summarize();
  end
endmodule
